// ===== design/swss_top.sv
// Stop-mode wake source selector with AXI4-Lite register access
//
// Function
// - Wake source comes from bits four down to two of wake control two.
// - Code 001 NANDs port 2 pins 3..0; code 010 NANDs pins 7..0.
// - Code 011 NORs port 3 pins 3..1; code 100 NANDs them.
// - Codes 101/110 NOR/NAND port 3 pins 3..1 with port 0 pins 0, 7.
// - Code 111 NANDs port 3 pins 3..1 with port 2 pins 2..0.
// - Pins configured as outputs never contribute to wake.
// - Power-on reset clears level bit and source field.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module swss_top
	import swss_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [swss_pkg::SWSS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                  s_axi_awprot,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [swss_pkg::SWSS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                  s_axi_arprot,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	input  wire logic                        stop_req,
	input  wire logic                        recovery_done,
	input  wire logic [7:0]                  port_zero_pins,
	input  wire logic [7:0]                  port_two_pins,
	input  wire logic [2:0]                  port_three_pins_three_to_one,
	input  wire logic [7:0]                  port_zero_dir_out,
	input  wire logic [7:0]                  port_two_dir_out,
	input  wire logic [2:0]                  port_three_dir_out,
	output logic                             stop_mode_r,
	output logic                             wake_r
);
	import swss_pkg::*;

	// ----------------------------------------------------------------
	// Pin input filtering
	// ----------------------------------------------------------------
	logic [SWSS_NPIN-1:0] pin_raw;
	logic [SWSS_NPIN-1:0] pin_out;
	logic [SWSS_NPIN-1:0] pin_v_r;
	logic [SWSS_NPIN-1:0] pin_v_nxt;
	logic [SWSS_NPIN-1:0] s1_r;
	logic [SWSS_NPIN-1:0] s2_r;
	logic [SWSS_NPIN-1:0] s3_r;

	assign pin_raw = {port_three_pins_three_to_one, port_two_pins,
		port_zero_pins[7], port_zero_pins[0]};
	assign pin_out = {port_three_dir_out, port_two_dir_out,
		port_zero_dir_out[7], port_zero_dir_out[0]};

	// A level counts only once two later stages agree, so a pin bouncing
	// across an edge cannot glitch the wake decision
	genvar gi;
	generate
		for (gi = 0; gi < SWSS_NPIN; gi++) begin : g_pin
			always_comb begin
				pin_v_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : pin_v_r[gi];
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			pin_v_r <= '0;
		end else begin
			s1_r    <= pin_raw;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			pin_v_r <= pin_v_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Register file and AXI4-Lite slave
	// ----------------------------------------------------------------
	logic [2:0]  src_r, src_nxt;
	logic        level_r, level_nxt;
	logic        aw_ok_r, aw_ok_nxt;
	logic        w_ok_r, w_ok_nxt;
	logic [SWSS_ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [7:0]  wbyte_r, wbyte_nxt;
	logic        wstb_r, wstb_nxt;
	logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic        cond_r;
	swss_state_e state_r, state_nxt;

	always_comb begin
		src_nxt     = src_r;
		level_nxt   = level_r;
		aw_ok_nxt   = aw_ok_r;
		w_ok_nxt    = w_ok_r;
		awaddr_nxt  = awaddr_r;
		wbyte_nxt   = wbyte_r;
		wstb_nxt    = wstb_r;
		bvalid_nxt  = s_axi_bvalid;
		bresp_nxt   = s_axi_bresp;
		rvalid_nxt  = s_axi_rvalid;
		rresp_nxt   = s_axi_rresp;
		rdata_nxt   = s_axi_rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_nxt  = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_ok_nxt  = 1'b1;
			wbyte_nxt = s_axi_wdata[7:0];
			wstb_nxt  = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
			aw_ok_nxt  = 1'b0;
			w_ok_nxt   = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt  = SWSS_RESP_OKAY;
			if (awaddr_r == SWSS_ADDR_WAKE_CTL2) begin
				// Reserved bits are dropped whatever software writes
				if (wstb_r) begin
					src_nxt   = wbyte_r[SWSS_SRC_HI:SWSS_SRC_LO];
					level_nxt = wbyte_r[SWSS_LEVEL_BIT];
				end
			end else if (awaddr_r != SWSS_ADDR_STATUS) begin
				bresp_nxt = SWSS_RESP_SLVERR;
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = SWSS_RESP_OKAY;
			rdata_nxt  = 32'h0000_0000;
			if (s_axi_araddr == SWSS_ADDR_STATUS) begin
				rdata_nxt[SWSS_ST_STOP] = stop_mode_r;
				rdata_nxt[SWSS_ST_WAKE] = wake_r;
				rdata_nxt[SWSS_ST_COND] = cond_r;
			end else if (s_axi_araddr != SWSS_ADDR_WAKE_CTL2) begin
				rresp_nxt = SWSS_RESP_SLVERR;
			end
		end
		// Write-only control reads back as zero
		awready_nxt = !aw_ok_nxt && !bvalid_nxt;
		wready_nxt  = !w_ok_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_r         <= SWSS_SRC_RST;
			level_r       <= SWSS_LEVEL_RST;
			aw_ok_r       <= 1'b0;
			w_ok_r        <= 1'b0;
			awaddr_r      <= '0;
			wbyte_r       <= 8'h00;
			wstb_r        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= SWSS_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= SWSS_RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
		end else begin
			src_r         <= src_nxt;
			level_r       <= level_nxt;
			aw_ok_r       <= aw_ok_nxt;
			w_ok_r        <= w_ok_nxt;
			awaddr_r      <= awaddr_nxt;
			wbyte_r       <= wbyte_nxt;
			wstb_r        <= wstb_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready  <= wready_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rresp   <= rresp_nxt;
			s_axi_rdata   <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Wake combination
	// ----------------------------------------------------------------
	swss_combine u_combine (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src     (src_r),
		.level   (level_r),
		.pin_v   (pin_v_r),
		.pin_out (pin_out),
		.cond_r  (cond_r)
	);

	// ----------------------------------------------------------------
	// Stop and recovery sequencing
	// ----------------------------------------------------------------
	// This clock must keep running in stop; a truly clockless detector
	// would need an asynchronous latch outside this block
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SWSS_RUN: begin
				if (stop_req) begin
					state_nxt = SWSS_STOP;
				end
			end
			SWSS_STOP: begin
				// A condition left over from an earlier source must not end a reset-only stop
				if (cond_r && src_r != SWSS_SRC_POR) begin
					state_nxt = SWSS_WAKE;
				end
			end
			SWSS_WAKE: begin
				if (recovery_done) begin
					state_nxt = SWSS_RUN;
				end
			end
			default: state_nxt = SWSS_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r     <= SWSS_RUN;
			stop_mode_r <= 1'b0;
			wake_r      <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			stop_mode_r <= (state_nxt != SWSS_RUN);
			wake_r      <= (state_nxt == SWSS_WAKE);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_ctl_write;
		aw_ok_r && w_ok_r && !s_axi_bvalid && wstb_r && awaddr_r == SWSS_ADDR_WAKE_CTL2;
	endsequence

	a_src_capture: assert property (s_ctl_write |=>
		src_r == $past(wbyte_r[4:2]) && s_axi_bvalid)
		else $error("Source field not taken from bits four to two");
	a_por_stays: assert property ((state_r == SWSS_STOP && src_r == SWSS_SRC_POR)
		|=> !wake_r)
		else $error("Stop ended with source 000");
	// Reset itself is the trigger here, so the default disable must not apply
	a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> src_r == SWSS_SRC_RST && level_r == SWSS_LEVEL_RST)
		else $error("Reset left wake control fields set");
	a_wake_held: assert property ((wake_r && !recovery_done) [*2] |=> wake_r && stop_mode_r)
		else $error("Wake detection dropped before recovery done");
	a_wake_path: assert property ((state_r == SWSS_STOP && cond_r && src_r != SWSS_SRC_POR)
		##1 !recovery_done |-> wake_r)
		else $error("Wake condition in stop not acted on");
	a_level_capture: assert property (s_ctl_write |=>
		level_r == $past(wbyte_r[SWSS_LEVEL_BIT]))
		else $error("Level bit not taken from bit six");
	a_stop_entry: assert property ((state_r == SWSS_RUN && stop_req) |=>
		stop_mode_r && !wake_r)
		else $error("Stop request not entered");
	a_recovery_end: assert property ((state_r == SWSS_WAKE && recovery_done) |=>
		!stop_mode_r && !wake_r)
		else $error("Recovery done did not end stop");
	a_bresp_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("Write response dropped before bready");
	a_rdata_hold: assert property ((s_axi_rvalid && !s_axi_rready) |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("Read data dropped before rready");
	a_wo_readback: assert property ((s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == SWSS_ADDR_WAKE_CTL2) |=> s_axi_rdata == 32'h0000_0000)
		else $error("Write-only control did not read back as zero");
endmodule : swss_top
`default_nettype wire

// ===== design/swss_pkg.sv
// Constants shared by the stop-mode wake source selector
package swss_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  SWSS_IDX_WAKE_CTL2 = 8'h0D;
	localparam logic [7:0]  SWSS_IDX_STATUS    = 8'h0E;
	localparam logic [11:0] SWSS_ADDR_WAKE_CTL2 = {2'b00, SWSS_IDX_WAKE_CTL2, 2'b00};
	localparam logic [11:0] SWSS_ADDR_STATUS    = {2'b00, SWSS_IDX_STATUS, 2'b00};
	localparam int          SWSS_ADDR_W        = 12;

	// Wake control two field layout
	localparam int          SWSS_LEVEL_BIT     = 6;
	localparam int          SWSS_SRC_HI        = 4;
	localparam int          SWSS_SRC_LO        = 2;
	localparam logic [2:0]  SWSS_SRC_RST       = 3'h0;
	localparam logic        SWSS_LEVEL_RST     = 1'b0;

	// Status register bits
	localparam int          SWSS_ST_STOP       = 0;
	localparam int          SWSS_ST_WAKE       = 1;
	localparam int          SWSS_ST_COND       = 2;

	// Source codes
	localparam logic [2:0]  SWSS_SRC_POR       = 3'h0;
	localparam logic [2:0]  SWSS_SRC_P2_LO     = 3'h1;
	localparam logic [2:0]  SWSS_SRC_P2_ALL    = 3'h2;
	localparam logic [2:0]  SWSS_SRC_P3_NOR    = 3'h3;
	localparam logic [2:0]  SWSS_SRC_P3_NAND   = 3'h4;
	localparam logic [2:0]  SWSS_SRC_P30_NOR   = 3'h5;
	localparam logic [2:0]  SWSS_SRC_P30_NAND  = 3'h6;
	localparam logic [2:0]  SWSS_SRC_P32_NAND  = 3'h7;

	// Pin vector: [1:0]={p0.7,p0.0}, [9:2]=port 2, [12:10]=port 3 pins 3..1
	localparam int          SWSS_NPIN          = 13;
	localparam logic [12:0] SWSS_SEL_P2_LO     = 13'h003C;
	localparam logic [12:0] SWSS_SEL_P2_ALL    = 13'h03FC;
	localparam logic [12:0] SWSS_SEL_P3        = 13'h1C00;
	localparam logic [12:0] SWSS_SEL_P30       = 13'h1C03;
	localparam logic [12:0] SWSS_SEL_P32       = 13'h1C1C;

	localparam logic [1:0]  SWSS_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  SWSS_RESP_SLVERR   = 2'h2;

	typedef enum logic [2:0] {
		SWSS_RUN  = 3'b001,
		SWSS_STOP = 3'b010,
		SWSS_WAKE = 3'b100
	} swss_state_e;
endpackage : swss_pkg

// ===== design/swss_combine.sv
// Wake combination: selects pins, drops outputs, applies NAND or NOR and level
`timescale 1ns/100ps
`default_nettype none
module swss_combine
	import swss_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [2:0]            src,
	input  wire logic                  level,
	input  wire logic [swss_pkg::SWSS_NPIN-1:0] pin_v,
	input  wire logic [swss_pkg::SWSS_NPIN-1:0] pin_out,
	output logic                                cond_r
);
	import swss_pkg::*;

	logic cond_nxt;

	function automatic logic [12:0] sel_of(input logic [2:0] code);
		case (code)
			SWSS_SRC_P2_LO:                     sel_of = SWSS_SEL_P2_LO;
			SWSS_SRC_P2_ALL:                    sel_of = SWSS_SEL_P2_ALL;
			SWSS_SRC_P3_NOR, SWSS_SRC_P3_NAND:  sel_of = SWSS_SEL_P3;
			SWSS_SRC_P30_NOR, SWSS_SRC_P30_NAND: sel_of = SWSS_SEL_P30;
			SWSS_SRC_P32_NAND:                  sel_of = SWSS_SEL_P32;
			default:                            sel_of = '0;
		endcase
	endfunction : sel_of

	always_comb begin
		logic [12:0] en;
		logic        res;
		en  = sel_of(src) & ~pin_out;
		res = 1'b0;
		if (src == SWSS_SRC_P3_NOR || src == SWSS_SRC_P30_NOR) begin
			res = ~|(pin_v & en);
		end else begin
			res = ~&(pin_v | ~en);
		end
		// No selected input pin left means nothing can wake
		cond_nxt = (|en) && (res == level);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cond_r <= 1'b0;
		end else begin
			cond_r <= cond_nxt;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_por_only_quiet: assert property ((src == SWSS_SRC_POR) |=> !cond_r)
		else $error("Source 000 produced a wake condition");
	a_p2lo_nand: assert property ((src == SWSS_SRC_P2_LO && level && !pin_v[2] && !pin_out[2])
		|=> cond_r)
		else $error("Port 2 low nibble NAND missed a low pin");
	a_p2all_nand: assert property ((src == SWSS_SRC_P2_ALL && level && !pin_v[9] && !pin_out[9])
		|=> cond_r)
		else $error("Port 2 full NAND missed pin seven low");
	a_p3_nor: assert property ((src == SWSS_SRC_P3_NOR && !level && pin_v[11] && !pin_out[11])
		|=> cond_r)
		else $error("Port 3 NOR missed a high pin");
	a_p3_nand: assert property ((src == SWSS_SRC_P3_NAND && level && !pin_v[12] && !pin_out[12])
		|=> cond_r)
		else $error("Port 3 NAND missed a low pin");
	a_p30_nor: assert property ((src == SWSS_SRC_P30_NOR && !level && pin_v[1] && !pin_out[1])
		|=> cond_r)
		else $error("Port 3 and 0 NOR missed pin 0.7 high");
	a_p30_nand: assert property ((src == SWSS_SRC_P30_NAND && level && !pin_v[0] && !pin_out[0])
		|=> cond_r)
		else $error("Port 3 and 0 NAND missed pin 0.0 low");
	a_p32_nand: assert property ((src == SWSS_SRC_P32_NAND && level && !pin_v[4] && !pin_out[4])
		|=> cond_r)
		else $error("Port 3 and 2 NAND missed pin 2.2 low");
	a_level_low: assert property ((src == SWSS_SRC_P2_LO && !level && !pin_v[3] && !pin_out[3])
		|=> !cond_r)
		else $error("Low level select woke on a high NAND result");
	a_outputs_ignored: assert property ((&pin_out) |=> !cond_r)
		else $error("Output pins contributed to wake");
endmodule : swss_combine
`default_nettype wire

// ===== tb/swss_pin_model.sv
// Port pin model that drives the wake inputs and their direction bits
`timescale 1ns/100ps
`default_nettype none
module swss_pin_model (
	input  wire logic        aclk,
	input  wire logic [12:0] pin_set,
	input  wire logic [12:0] dir_set,
	output logic      [7:0]  port_zero_pins,
	output logic      [7:0]  port_two_pins,
	output logic      [2:0]  port_three_pins_three_to_one,
	output logic      [7:0]  port_zero_dir_out,
	output logic      [7:0]  port_two_dir_out,
	output logic      [2:0]  port_three_dir_out
);
	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	logic [5:0] noise_r = 6'h00;

	// Port 0 pins 1..6 never take part, so they follow a free-running count to expose a stray use
	always_ff @(posedge aclk) begin
		noise_r <= noise_r + 6'h01;
	end

	// Vector order: [0]=port 0 pin 0, [1]=port 0 pin 7, [9:2]=port 2, [12:10]=port 3 pins 3..1
	assign port_zero_pins               = {pin_set[1], noise_r, pin_set[0]};
	assign port_two_pins                = pin_set[9:2];
	assign port_three_pins_three_to_one = pin_set[12:10];
	assign port_zero_dir_out            = {dir_set[1], ~noise_r, dir_set[0]};
	assign port_two_dir_out             = dir_set[9:2];
	assign port_three_dir_out           = dir_set[12:10];
endmodule : swss_pin_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the stop-mode wake source selector
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import swss_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic        stop_req = 1'h0, recovery_done = 1'h0;
	logic [12:0] pin_set = 13'h0000, dir_set = 13'h0000;
	wire logic        awready, wready, bvalid, arready, rvalid, stop_mode, wake;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0]  pz, p2, dz, d2;
	wire logic [2:0]  p3, d3;
	int          failures = 0;
	int          samples_checked = 0;

	always #10 aclk = ~aclk;

	swss_pin_model swss_pin_model_i (.aclk(aclk), .pin_set(pin_set), .dir_set(dir_set),
		.port_zero_pins(pz), .port_two_pins(p2), .port_three_pins_three_to_one(p3),
		.port_zero_dir_out(dz), .port_two_dir_out(d2), .port_three_dir_out(d3));

	swss_top swss_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .stop_req(stop_req),
		.recovery_done(recovery_done), .port_zero_pins(pz), .port_two_pins(p2),
		.port_three_pins_three_to_one(p3), .port_zero_dir_out(dz), .port_two_dir_out(d2),
		.port_three_dir_out(d3), .stop_mode_r(stop_mode), .wake_r(wake));

	// ----------------------------------------
	// Tasks and functions
	// ----------------------------------------
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic hang(input string what);
		failures++;
		$display("[ERR] %s expected an answer seen none", what);
		complete_run();
	endtask : hang

	task automatic reset_dut;
		aresetn <= 1'h0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
	endtask : reset_dut

	task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		awvalid <= 1'h1;
		awaddr <= a;
		wvalid <= 1'h1;
		wdata <= d;
		bready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid && bready)
				break;
		end
		if (n == 50)
			hang("write response");
		resp = bresp;
		bready <= 1'h0;
	endtask : axi_write

	task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		arvalid <= 1'h1;
		araddr <= a;
		rready <= 1'h1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid && rready)
				break;
		end
		if (n == 50)
			hang("read data");
		d = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask : axi_read

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Output pins are neutral; with every selected pin an output nothing can wake
	function automatic logic exp_cond(input logic [2:0] src, input logic lvl,
		input logic [12:0] pv, input logic [12:0] ov);
		logic [12:0] act;
		logic        res;
		logic        nor_g;
		case (src)
			3'h1: act = 13'h003C;
			3'h2: act = 13'h03FC;
			3'h3, 3'h4: act = 13'h1C00;
			3'h5, 3'h6: act = 13'h1C03;
			3'h7: act = 13'h1C1C;
			default: act = 13'h0000;
		endcase
		act = act & ~ov;
		// NOR starts high and any active high pin pulls it low; NAND the mirror image
		nor_g = (src == 3'h3 || src == 3'h5);
		res = nor_g;
		for (int k = 0; k < 13; k++) begin
			if (act[k] && nor_g && pv[k])
				res = 1'b0;
			if (act[k] && !nor_g && !pv[k])
				res = 1'b1;
		end
		return (act != 13'h0000) && (res == lvl);
	endfunction : exp_cond

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [31:0] d;
		logic [1:0]  resp;
		logic [2:0]  src;
		logic [12:0] dv;
		logic        lvl;
		logic        c;
		int          n;
		r = 32'h0001_8347;
		reset_dut();
		axi_read(SWSS_ADDR_WAKE_CTL2, d, resp);
		chk("write-only read", 32'h0000_0000, d);
		chk("write-only resp", {30'h0000_0000, SWSS_RESP_OKAY}, {30'h0000_0000, resp});
		axi_read(SWSS_ADDR_STATUS, d, resp);
		chk("status at reset", 32'h0000_0000, d);
		axi_read(12'h100, d, resp);
		chk("unmapped read", {30'h0000_0000, resp}, {30'h0000_0000, SWSS_RESP_SLVERR});
		axi_write(12'h100, 32'h0000_007C, resp);
		chk("unmapped write", {30'h0000_0000, resp}, {30'h0000_0000, SWSS_RESP_SLVERR});
		for (int i = 0; i < 48; i++) begin
			r = lfsr(r);
			src = (i < 16) ? i[3:1] : r[2:0];
			lvl = (i < 16) ? i[0] : r[3];
			dv = (i < 16) ? 13'h0000 : (i == 16) ? 13'h1FFF : r[29:17] & r[12:0];
			pin_set <= r[16:4];
			dir_set <= dv;
			c = exp_cond(src, lvl, r[16:4], dv);
			axi_write(SWSS_ADDR_WAKE_CTL2, {24'h00_0000, 1'h0, lvl, 1'h0, src, 2'h0}, resp);
			chk("control write", {30'h0000_0000, resp}, {30'h0000_0000, SWSS_RESP_OKAY});
			repeat (10) @(posedge aclk);
			axi_read(SWSS_ADDR_STATUS, d, resp);
			chk("wake condition", {29'h0000_0000, c, 2'h0}, d);
			stop_req <= 1'h1;
			@(posedge aclk);
			stop_req <= 1'h0;
			@(posedge aclk);
			chk("stop entry", 32'h0000_0001, {31'h0000_0000, stop_mode});
			for (n = 0; n < 12 && !(c && wake === 1'h1); n++)
				@(posedge aclk);
			chk("wake flag", {31'h0000_0000, c}, {31'h0000_0000, wake});
			if (c) begin
				pin_set <= ~r[16:4];
				repeat (10) @(posedge aclk);
				chk("wake held", 32'h0000_0001, {31'h0000_0000, wake});
				recovery_done <= 1'h1;
				@(posedge aclk);
				recovery_done <= 1'h0;
				@(posedge aclk);
				chk("wake end", 32'h0000_0000, {30'h0000_0000, wake, stop_mode});
			end else begin
				reset_dut();
				axi_read(SWSS_ADDR_STATUS, d, resp);
				chk("status after reset", 32'h0000_0000, d);
			end
		end
		complete_run();
	end
endmodule : testbench
`default_nettype wire
